// ---- verilog/trig_level_ctrl.sv ----
/*
 Trigger level and slope control with an AHB-Lite register slave.
 Assumes a single AHB-Lite master on hclk, samples from logic on hclk,
 and the record capture logic consuming trig_pulse and trig_offset.
*/
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module trig_level_ctrl
   import trig_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic signed [15:0] sample_in,
   input wire logic sample_valid,
   output logic trig_pulse,
   output logic signed [17:0] trig_offset,
   output logic measure_run
);
   import trig_pkg::*;

   typedef struct packed {
      logic act;
      logic wr;
      logic [7:0] addr;
      logic [31:0] rdata;
      logic ready;
      logic signed [15:0] level;
      logic [1:0] auto_code;
      logic [1:0] pos;
      logic slope;
      logic [7:0] hyst;
      logic normal;
      logic pulse;
      logic signed [15:0] delay;
      logic reject;
      logic signed [15:0] active;
      logic signed [15:0] smin;
      logic signed [15:0] smax;
      logic [5:0] scount;
      logic run;
      logic [7:0] idle_cnt;
      logic trig;
      logic signed [17:0] offset;
   } ctrl_s;

   localparam ctrl_s RST_STATE = '{
      act: 1'b0, wr: 1'b0, addr: 8'h00, rdata: 32'h0, ready: 1'b1,
      level: LEVEL_DEF, auto_code: AUTO_ON, pos: POS_LEFT,
      slope: SLOPE_RISING, hyst: HYST_DEF, normal: 1'b0, pulse: 1'b0,
      delay: 16'sh0, reject: 1'b0, active: LEVEL_DEF, smin: 16'sh0,
      smax: 16'sh0, scount: 6'h0, run: 1'b1, idle_cnt: 8'h0,
      trig: 1'b0, offset: 18'sh0};

   ctrl_s st_reg;
   ctrl_s st_next;
   trig_cmp_if cmp ();
   logic addr_phase;
   logic data_wr;
   logic signed [15:0] lo_v;
   logic signed [15:0] hi_v;
   logic signed [16:0] mid_sum;
   logic signed [15:0] wval;

   // ----------------------------------------------------------------
   // Crossing detector
   // ----------------------------------------------------------------
   assign cmp.sample = sample_in;
   assign cmp.valid = sample_valid;
   assign cmp.threshold = st_reg.active;
   assign cmp.hyst = st_reg.hyst;
   assign cmp.slope = st_reg.slope;

   trig_crossing u_cross (
      .hclk(hclk),
      .hresetn(hresetn),
      .cmp(cmp)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Zero wait states: read data is sampled in the address phase, so a
   // read right after a write to the same register returns the old value.
   always_comb
   begin
      st_next = st_reg;
      addr_phase = hsel && htrans[1] && hready;
      data_wr = st_reg.act && st_reg.wr;
      wval = hwdata[15:0];
      lo_v = st_reg.smin;
      hi_v = st_reg.smax;
      mid_sum = 17'sh0;

      st_next.ready = 1'b1;
      st_next.act = addr_phase;
      st_next.wr = hwrite && hsize == WORD_SIZE;
      st_next.addr = {haddr[7:2], 2'b00};
      st_next.rdata = 32'h0;

      if (addr_phase && !hwrite)
      begin
         case ({haddr[7:2], 2'b00})
            ADDR_LEVEL: st_next.rdata = sext16(st_reg.level);
            ADDR_LIMITS: st_next.rdata = {LEVEL_MAX, LEVEL_MIN};
            ADDR_AUTO: st_next.rdata = {31'h0, st_reg.auto_code == AUTO_ON};
            ADDR_POS: st_next.rdata = {30'h0, st_reg.pos};
            ADDR_SLOPE: st_next.rdata = {31'h0, st_reg.slope};
            ADDR_HYST: st_next.rdata = {24'h0, st_reg.hyst};
            ADDR_MODE: st_next.rdata = {30'h0, st_reg.pulse, st_reg.normal};
            ADDR_DELAY: st_next.rdata = sext16(st_reg.delay);
            ADDR_STATUS: st_next.rdata = {29'h0, st_reg.reject, st_reg.run,
                                          st_reg.auto_code != AUTO_OFF};
            ADDR_ACTIVE: st_next.rdata = sext16(st_reg.active);
            default: st_next.rdata = 32'h0;
         endcase
      end

      // Writes take effect in the data phase.
      if (data_wr)
      begin
         case (st_reg.addr)
            ADDR_LEVEL:
            begin
               if (hwdata[DEFAULT_BIT])
                  st_next.level = LEVEL_DEF;
               else if (wval >= LEVEL_MIN && wval <= LEVEL_MAX)
                  st_next.level = wval;
               else
                  st_next.reject = 1'b1;
            end
            ADDR_AUTO:
            begin
               if (hwdata[1:0] != 2'h3)
               begin
                  st_next.auto_code = hwdata[1:0];
                  st_next.scount = 6'h0;
               end
               else
                  st_next.reject = 1'b1;
            end
            ADDR_POS:
            begin
               if (hwdata[1:0] <= POS_RIGHT)
                  st_next.pos = hwdata[1:0];
               else
                  st_next.reject = 1'b1;
            end
            ADDR_SLOPE: st_next.slope = hwdata[0];
            ADDR_HYST:
            begin
               if (hwdata[DEFAULT_BIT])
                  st_next.hyst = HYST_DEF;
               else if (hwdata[15:0] <= {8'h0, HYST_MAX})
                  st_next.hyst = hwdata[7:0];
               else
                  st_next.reject = 1'b1;
            end
            ADDR_MODE:
            begin
               st_next.normal = hwdata[0];
               st_next.pulse = hwdata[1];
            end
            ADDR_DELAY: st_next.delay = wval;
            ADDR_STATUS:
            begin
               if (hwdata[REJECT_BIT])
                  st_next.reject = 1'b0;
            end
            default: st_next.reject = st_reg.reject;
         endcase
      end

      // Threshold source: programmed level, or found by search.
      if (st_reg.auto_code == AUTO_OFF)
         st_next.active = st_reg.level;
      else if (sample_valid && !data_wr)
      begin
         if (st_reg.scount == 6'h0)
         begin
            lo_v = sample_in;
            hi_v = sample_in;
         end
         else
         begin
            if (sample_in < lo_v)
               lo_v = sample_in;
            if (sample_in > hi_v)
               hi_v = sample_in;
         end
         st_next.smin = lo_v;
         st_next.smax = hi_v;
         st_next.scount = st_reg.scount + 6'h1;
         if (st_reg.scount == SEARCH_LAST)
         begin
            mid_sum = 17'(lo_v) + 17'(hi_v);
            st_next.active = mid_sum[16:1];
            st_next.scount = 6'h0;
            if (st_reg.auto_code == AUTO_ONCE)
               st_next.auto_code = AUTO_OFF;
         end
      end

      // Measurement run: auto mode never halts for lack of triggers.
      st_next.trig = cmp.trig;
      if (!st_reg.normal)
      begin
         st_next.run = 1'b1;
         st_next.idle_cnt = 8'h0;
      end
      else if (cmp.trig)
      begin
         st_next.run = 1'b1;
         st_next.idle_cnt = 8'h0;
      end
      else if (sample_valid)
      begin
         if (st_reg.idle_cnt == RUN_HOLD_LAST)
            st_next.run = 1'b0;
         else
            st_next.idle_cnt = st_reg.idle_cnt + 8'h1;
      end

      // Placement counts only in pulse mode; delay always adds on.
      if (st_reg.pulse)
         st_next.offset = place_offset(st_reg.pos) +
                          18'(st_reg.delay);
      else
         st_next.offset = 18'(st_reg.delay);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= RST_STATE;
      else
         st_reg <= st_next;
   end

   assign hrdata = st_reg.rdata;
   assign hreadyout = st_reg.ready;
   assign hresp = 1'b0;
   assign trig_pulse = st_reg.trig;
   assign trig_offset = st_reg.offset;
   assign measure_run = st_reg.run;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_level_span;
      st_reg.level >= LEVEL_MIN && st_reg.level <= LEVEL_MAX;
   endproperty
   a_level_span: assert property (p_level_span)
      else $error("Threshold outside its span.");

   property p_level_default;
      data_wr && st_reg.addr == ADDR_LEVEL && hwdata[DEFAULT_BIT]
         |=> st_reg.level == LEVEL_DEF;
   endproperty
   a_level_default: assert property (p_level_default)
      else $error("Default threshold write not applied.");

   sequence s_auto_read;
      addr_phase && !hwrite && haddr[7:0] == ADDR_AUTO ##1 1'b1;
   endsequence
   property p_auto_report;
      s_auto_read |-> hrdata == {31'h0, $past(st_reg.auto_code) == AUTO_ON};
   endproperty
   a_auto_report: assert property (p_auto_report)
      else $error("Search mode read back wrong.");

   sequence s_once_done;
      st_reg.auto_code == AUTO_ONCE && sample_valid && !data_wr &&
         st_reg.scount == SEARCH_LAST;
   endsequence
   property p_once_ends;
      s_once_done |=> st_reg.auto_code == AUTO_OFF ##1
         st_reg.active == $past(st_reg.level);
   endproperty
   a_once_ends: assert property (p_once_ends)
      else $error("One-shot search did not fall back.");

   property p_off_tracks;
      st_reg.auto_code == AUTO_OFF |=> st_reg.active == $past(st_reg.level);
   endproperty
   a_off_tracks: assert property (p_off_tracks)
      else $error("Threshold not following programmed level.");

   property p_offset;
      1'b1 |=> trig_offset == ($past(st_reg.pulse) ?
         place_offset($past(st_reg.pos)) : 18'sh0) + 18'($past(st_reg.delay));
   endproperty
   a_offset: assert property (p_offset)
      else $error("Trigger offset wrong.");

   property p_run_auto;
      !st_reg.normal |=> measure_run;
   endproperty
   a_run_auto: assert property (p_run_auto)
      else $error("Measurement halted in auto mode.");

   property p_trig_resumes;
      st_reg.normal && cmp.trig |=> measure_run && trig_pulse;
   endproperty
   a_trig_resumes: assert property (p_trig_resumes)
      else $error("Trigger did not resume measurement.");

   property p_pos_code;
      st_reg.pos <= POS_RIGHT && st_reg.hyst <= HYST_MAX;
   endproperty
   a_pos_code: assert property (p_pos_code)
      else $error("Placement or hysteresis out of range.");

endmodule // trig_level_ctrl
`default_nettype wire

// ---- verilog/trig_pkg.sv ----
/*
 Constants, register map and helper functions of the trigger level and
 slope control block. Assumes power samples arrive as signed 16-bit
 values in sixteenths of a dBm, one per sample_valid pulse on hclk.
*/
package trig_pkg;

   // ----------------------------------------------------------------
   // Units and limits
   // ----------------------------------------------------------------
   localparam int FRAC_PER_DB = 16;
   localparam int LEVEL_MIN_DBM = -40;
   localparam int LEVEL_MAX_DBM = 20;
   localparam int LEVEL_DEF_DBM = -5;
   localparam int HYST_MAX_DB = 3;
   localparam int HYST_DEF_DB = 0;
   localparam logic signed [15:0] LEVEL_MIN = 16'(LEVEL_MIN_DBM * FRAC_PER_DB);
   localparam logic signed [15:0] LEVEL_MAX = 16'(LEVEL_MAX_DBM * FRAC_PER_DB);
   localparam logic signed [15:0] LEVEL_DEF = 16'(LEVEL_DEF_DBM * FRAC_PER_DB);
   localparam logic [7:0] HYST_MAX = 8'(HYST_MAX_DB * FRAC_PER_DB);
   localparam logic [7:0] HYST_DEF = 8'(HYST_DEF_DB * FRAC_PER_DB);

   // ----------------------------------------------------------------
   // Codes, placement and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] AUTO_OFF = 2'h0;
   localparam logic [1:0] AUTO_ON = 2'h1;
   localparam logic [1:0] AUTO_ONCE = 2'h2;
   localparam logic [1:0] POS_LEFT = 2'h0;
   localparam logic [1:0] POS_MIDDLE = 2'h1;
   localparam logic [1:0] POS_RIGHT = 2'h2;
   localparam logic SLOPE_RISING = 1'b0;
   localparam int DIV_SAMPLES = 16;
   localparam int DIVS_MIDDLE = 5;
   localparam int DIVS_RIGHT = 10;
   localparam logic [5:0] SEARCH_LAST = 6'h3f;
   localparam logic [7:0] RUN_HOLD_LAST = 8'hc7;
   localparam logic [2:0] WORD_SIZE = 3'h2;
   localparam int DEFAULT_BIT = 16;
   localparam int REJECT_BIT = 2;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_LEVEL = 8'h00;
   localparam logic [7:0] ADDR_LIMITS = 8'h04;
   localparam logic [7:0] ADDR_AUTO = 8'h08;
   localparam logic [7:0] ADDR_POS = 8'h0c;
   localparam logic [7:0] ADDR_SLOPE = 8'h10;
   localparam logic [7:0] ADDR_HYST = 8'h14;
   localparam logic [7:0] ADDR_MODE = 8'h18;
   localparam logic [7:0] ADDR_DELAY = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_ACTIVE = 8'h24;

   function automatic logic signed [17:0] place_offset(input logic [1:0] pos);
      logic signed [17:0] r;
      r = 18'sh0;
      if (pos == POS_MIDDLE)
         r = 18'(DIVS_MIDDLE * DIV_SAMPLES);
      else if (pos == POS_RIGHT)
         r = 18'(DIVS_RIGHT * DIV_SAMPLES);
      return r;
   endfunction

   function automatic logic [31:0] sext16(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction

endpackage

// ---- verilog/trig_cmp_if.sv ----
/*
 Interface between the control block and its crossing detector.
 Assumes both ends run on the same hclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface trig_cmp_if;
   logic signed [15:0] sample;
   logic valid;
   logic signed [15:0] threshold;
   logic [7:0] hyst;
   logic slope;
   logic trig;
   modport ctrl (output sample, valid, threshold, hyst, slope, input trig);
   modport det (input sample, valid, threshold, hyst, slope, output trig);
endinterface
`default_nettype wire

// ---- verilog/trig_crossing.sv ----
/*
 Crossing detector: compares each sample against the threshold with
 hysteresis on the chosen slope. Assumes inputs on hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module trig_crossing
   import trig_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   trig_cmp_if.det cmp
);
   typedef struct packed {
      logic armed;
      logic trig;
   } det_s;

   det_s st_reg;
   det_s st_next;
   logic signed [17:0] x;
   logic signed [17:0] thr;
   logic signed [17:0] lo;
   logic signed [17:0] hi;
   logic fire;
   logic arm;

   // ----------------------------------------------------------------
   // Crossing logic
   // ----------------------------------------------------------------
   // The sample must leave the hysteresis band on the far side before a
   // new crossing counts, so noise at the threshold gives one pulse.
   always_comb
   begin
      x = 18'(cmp.sample);
      thr = 18'(cmp.threshold);
      lo = thr - 18'(cmp.hyst);
      hi = thr + 18'(cmp.hyst);
      if (cmp.slope == SLOPE_RISING)
      begin
         fire = st_reg.armed && x >= thr;
         arm = x < lo;
      end
      else
      begin
         fire = st_reg.armed && x <= thr;
         arm = x > hi;
      end
      st_next = st_reg;
      st_next.trig = 1'b0;
      if (cmp.valid)
      begin
         if (fire)
         begin
            st_next.trig = 1'b1;
            st_next.armed = 1'b0;
         end
         else if (arm)
            st_next.armed = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign cmp.trig = st_reg.trig;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_single_pulse;
      cmp.trig |=> !cmp.trig;
   endproperty
   a_single_pulse: assert property (p_single_pulse)
      else $error("Trigger pulse longer than one cycle.");

   property p_rise_fire;
      cmp.valid && cmp.slope == SLOPE_RISING && st_reg.armed &&
         cmp.sample >= cmp.threshold |=> cmp.trig;
   endproperty
   a_rise_fire: assert property (p_rise_fire)
      else $error("Rising crossing did not trigger.");

   property p_fall_fire;
      cmp.valid && cmp.slope != SLOPE_RISING && st_reg.armed &&
         cmp.sample <= cmp.threshold |=> cmp.trig;
   endproperty
   a_fall_fire: assert property (p_fall_fire)
      else $error("Falling crossing did not trigger.");

   property p_needs_sample;
      cmp.trig |-> $past(cmp.valid) && $past(st_reg.armed);
   endproperty
   a_needs_sample: assert property (p_needs_sample)
      else $error("Trigger without an armed valid sample.");

endmodule // trig_crossing
`default_nettype wire

// ---- verif/trigger_level_slope_control_tb.sv ----
/*
 Self-checking bench of the trigger level and slope control block.
 Assumes the block answers AHB-Lite with zero wait states and that
 samples and bus traffic never overlap in these scenarios.
*/
`timescale 1ns/10ps
`default_nettype none
module trigger_level_slope_control_tb;
   import trig_pkg::*;

   // -------------------------------------------------------------
   // Signals and bookkeeping
   // -------------------------------------------------------------
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, trig_pulse, measure_run;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic signed [15:0] sample_in;
   logic sample_valid;
   logic signed [17:0] trig_offset;
   int bad_count = 0;
   int n_checks = 0;
   int dly, r;
   logic [31:0] rd_q[$];
   logic [7:0] ra_q[$];
   logic [1:0] tq[$];
   logic [1:0] p0 = 2'h2, p1 = 2'h2, nf;
   logic chk = 1'b0;
   logic rd_ph = 1'b0;
   logic [7:0] rd_a;
   // Flag 2 marks a sample whose trigger outcome is not judged.
   logic signed [15:0] tv [2][7] = '{'{-100, 50, 60, -10, 40, -30, 20},
                                     '{100, -50, -60, 10, -20, 30, -5}};
   logic [1:0] tf [2][7] = '{'{0, 1, 0, 0, 0, 0, 1}, '{0, 1, 0, 0, 0, 0, 1}};

   always #25 hclk = ~hclk;

   trig_level_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in),
      .sample_valid(sample_valid), .trig_pulse(trig_pulse),
      .trig_offset(trig_offset), .measure_run(measure_run));

   // -------------------------------------------------------------
   // Reporting
   // -------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Bus and sample drivers
   // -------------------------------------------------------------
   task automatic wait_ready;
      int i;
      i = 0;
      do
      begin
         @(posedge hclk);
         i++;
      end
      while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1)
      begin
         bad_count++;
         end_of_test;
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= sz;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d, WORD_SIZE);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      ra_q.push_back(a);
      ahb(1'b0, a, 32'h0, WORD_SIZE);
   endtask

   task automatic smp(input logic signed [15:0] v, input logic [1:0] f);
      @(posedge hclk);
      sample_in <= v;
      sample_valid <= 1'b1;
      tq.push_back(f);
   endtask

   task automatic sidle(input int n);
      @(posedge hclk);
      sample_valid <= 1'b0;
      repeat (n) @(posedge hclk);
   endtask

   // -------------------------------------------------------------
   // Output watcher: read data and trigger pulse timing
   // -------------------------------------------------------------
   always @(posedge hclk)
   begin
      if (rd_ph && rd_q.size() > 0)
      begin
         rd_a = ra_q.pop_front();
         check($sformatf("register %h", rd_a), rd_q.pop_front(), hrdata);
      end
      rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
      if (p1 != 2'h2)
         check("trig_pulse", {31'h0, p1[0]}, {31'h0, trig_pulse});
      nf = chk ? 2'h0 : 2'h2;
      if (sample_valid === 1'b1 && tq.size() > 0)
         nf = tq.pop_front();
      p1 = p0;
      p0 = nf;
   end

   // A hang anywhere is cut short here.
   initial
   begin
      repeat (30000) @(posedge hclk);
      bad_count++;
      end_of_test;
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = WORD_SIZE;
      hwdata = 32'h0;
      sample_in = 16'sh0;
      sample_valid = 1'b0;
      void'($urandom(32'h74ab));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ADDR_LEVEL, 32'hffffffb0);
      rd(ADDR_LIMITS, 32'h0140fd80);
      rd(ADDR_AUTO, 32'h1);
      rd(ADDR_POS, 32'h0);
      rd(ADDR_SLOPE, 32'h0);
      rd(ADDR_HYST, 32'h0);
      rd(ADDR_DELAY, 32'h0);
      rd(ADDR_ACTIVE, 32'hffffffb0);
      rd(ADDR_STATUS, 32'h3);
      rd(8'h40, 32'h0);
      check("trig_offset", 32'h0, 32'(trig_offset));
      check("hresp", 32'h0, {31'h0, hresp});
      wr(ADDR_AUTO, 32'h0);
      rd(ADDR_AUTO, 32'h0);
      wr(ADDR_AUTO, 32'h3);
      rd(ADDR_AUTO, 32'h0);
      rd(ADDR_STATUS, 32'h6);
      wr(ADDR_STATUS, 32'h4);
      rd(ADDR_STATUS, 32'h2);
      wr(ADDR_LEVEL, 32'h0000fd80);
      rd(ADDR_LEVEL, 32'hfffffd80);
      rd(ADDR_ACTIVE, 32'hfffffd80);
      wr(ADDR_LEVEL, 32'h140);
      wr(ADDR_LEVEL, 32'h141);
      rd(ADDR_LEVEL, 32'h140);
      wr(ADDR_LEVEL, 32'h0000fd7f);
      rd(ADDR_LEVEL, 32'h140);
      rd(ADDR_STATUS, 32'h6);
      wr(ADDR_STATUS, 32'h4);
      wr(ADDR_LEVEL, 32'h10000);
      rd(ADDR_LEVEL, 32'hffffffb0);
      ahb(1'b1, ADDR_LEVEL, 32'h0, 3'h0);
      rd(ADDR_LEVEL, 32'hffffffb0);
      wr(8'h40, 32'h5);
      rd(8'h40, 32'h0);
      r = $urandom_range(960) - 640;
      wr(ADDR_LEVEL, {16'h0, r[15:0]});
      rd(ADDR_LEVEL, 32'(r));
      // Crossings with one dB of hysteresis on both slopes.
      wr(ADDR_LEVEL, 32'h0);
      wr(ADDR_HYST, 32'h31);
      wr(ADDR_HYST, 32'h10);
      rd(ADDR_HYST, 32'h10);
      chk = 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         wr(ADDR_SLOPE, 32'(s));
         rd(ADDR_SLOPE, 32'(s));
         for (int i = 0; i < 7; i++)
            smp(tv[s][i], tf[s][i]);
         sidle(4);
      end
      wr(ADDR_HYST, 32'h10000);
      rd(ADDR_HYST, 32'h0);
      wr(ADDR_STATUS, 32'h4);
      // Placement and delay, in and out of pulse mode.
      dly = $urandom_range(64) - 32;
      for (int pm = 0; pm < 2; pm++)
         for (int p = 0; p < 3; p++)
         begin
            wr(ADDR_MODE, 32'(pm * 2));
            wr(ADDR_POS, 32'(p));
            wr(ADDR_DELAY, 32'(dly));
            rd(ADDR_POS, 32'(p));
            check("trig_offset", 32'(dly + pm * p * 80),
                  32'(trig_offset));
         end
      wr(ADDR_POS, 32'h3);
      rd(ADDR_POS, 32'h2);
      wr(ADDR_STATUS, 32'h4);
      // Normal mode stops without triggers; auto mode keeps running.
      wr(ADDR_SLOPE, 32'h0);
      wr(ADDR_MODE, 32'h1);
      for (int i = 0; i < 201; i++)
         smp(-16'sd200, 2'h0);
      sidle(2);
      check("measure_run", 32'h0, {31'h0, measure_run});
      rd(ADDR_STATUS, 32'h0);
      smp(16'sd100, 2'h1);
      sidle(4);
      check("measure_run", 32'h1, {31'h0, measure_run});
      wr(ADDR_MODE, 32'h0);
      for (int i = 0; i < 201; i++)
         smp(-16'sd200, 2'h0);
      sidle(2);
      check("measure_run", 32'h1, {31'h0, measure_run});
      // Threshold search, continuous and once.
      chk = 1'b0;
      wr(ADDR_AUTO, 32'h1);
      rd(ADDR_AUTO, 32'h1);
      for (int i = 0; i < 128; i++)
         smp(i[0] ? 16'sd0 : -16'sd320, 2'h2);
      sidle(8);
      rd(ADDR_ACTIVE, 32'hffffff60);
      wr(ADDR_AUTO, 32'h2);
      rd(ADDR_AUTO, 32'h0);
      for (int i = 0; i < 128; i++)
         smp(i[0] ? -16'sd160 : -16'sd480, 2'h2);
      sidle(8);
      rd(ADDR_AUTO, 32'h0);
      rd(ADDR_STATUS, 32'h2);
      rd(ADDR_ACTIVE, 32'h0);
      // A second reset brings the defaults back.
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ADDR_AUTO, 32'h1);
      rd(ADDR_LEVEL, 32'hffffffb0);
      repeat (4) @(posedge hclk);
      end_of_test;
   end

endmodule // trigger_level_slope_control_tb
`default_nettype wire
